// File: rate_feedback_divider_cascade_bench.sv
`timescale 1ns/100ps
module rate_feedback_divider_cascade_bench;
  import rfd_pkg::*;
  logic       sys_clk_i, rst_b_i, in_en_i, pclk, pen, present, inject, bor, nb_borrow, rate_n;
  logic       fb1_n, fb2_n, fb3_n, sync_n, slow_n, fast_n, slave, bo, fsync, psync_n;
  logic [3:0] a_n, b_n;
  logic [1:0] en_mode;
  logic [6:0] addr_n;
  logic [3:0] av[7], bv[7], d[5];
  rfd_fetch_t fetch_s;
  int         bad_count, comparisons, n;
  int         cnt[7];

  assign fetch_s = '{pclk, pen, a_n, b_n, nb_borrow};

  rfd_next_stage peer (.present_i(present), .inject_i(inject), .borrow_i(bor),
    .sync_n_i(sync_n), .follow_sync_n_i(fsync), .rate_n_o(rate_n), .borrow_o(nb_borrow),
    .prev_sync_n_o(psync_n));

  rfd_divider dut (.sys_clk_i(sys_clk_i), .rst_b_i(rst_b_i), .in_en_i(in_en_i),
    .fetch_i(fetch_s), .data_addr_n_o(addr_n), .rate_input_n_i(rate_n),
    .feedback_out_first_n_o(fb1_n), .feedback_out_second_n_o(fb2_n),
    .feedback_out_third_n_o(fb3_n), .sync_n_o(sync_n), .slow_divided_out_n_o(slow_n),
    .fast_out_n_o(fast_n), .slave_mode_o(slave));

  // 40 MHz clock
  initial begin
    sys_clk_i = 1'b0;
    forever #12.5 sys_clk_i = ~sys_clk_i;
  end

  // Divider input: off, every cycle, or with random gaps to stress spacing
  always @(posedge sys_clk_i) begin
    in_en_i <= (en_mode == 2'h1) | ((en_mode == 2'h2) & ($urandom % 3 != 0));
  end

  function automatic void check(input logic [31:0] got, input logic [31:0] exp);
    comparisons++;
    if (got !== exp) begin
      bad_count++;
      $display("MISMATCH t=%0t got=%h exp=%h", $time, got, exp);
    end
  endfunction

  task automatic end_sim;
    if (bad_count == 0 && comparisons > 0) $display("Test passed");
    else $display("Test failed");
    $finish;
  endtask

  // Subtractor digits with the borrow rippling upward from the lowest digit
  function automatic void calc();
    int   v;
    logic b;
    b = bor & present;
    for (int p = 0; p < 6; p++) begin
      v = int'(av[p]) - int'(bv[p]) - int'(b);
      b = (v < 0);
      if (p == 0) d[4] = 4'((v + 10) % 10);
      else if (p < 5) d[p-1] = 4'((v + 10) % 10);
    end
    bo = b;
  endfunction

  // One programme clock pulse; address outputs checked after rise and fall
  task automatic step(input logic [3:0] an, input logic [3:0] bn, input logic en,
                      input logic [2:0] er, input logic [2:0] ef);
    logic [6:0] e;
    @(posedge sys_clk_i);
    a_n <= an;
    b_n <= bn;
    pen <= en;
    repeat (2) @(posedge sys_clk_i);
    pclk <= 1'b1;
    repeat (4) @(posedge sys_clk_i);
    e = ~(7'h01 << er);
    check(addr_n, e);
    pclk <= 1'b0;
    repeat (4) @(posedge sys_clk_i);
    e = ~(7'h01 << ef);
    check(addr_n, e);
  endtask

  // Full fetch cycle; period 6 keeps modulus ten with the half counter off
  task automatic prog();
    step(4'hf, 4'hf, 1'b1, 3'h0, 3'h0);
    for (int p = 0; p < 6; p++) step(~av[p], ~bv[p], 1'b1, 3'(p + 1), 3'(p + 1));
    step(4'h5, 4'h0, 1'b1, 3'h7, 3'h7);
  endtask

  // Low cycles of each output over one full 1000-cycle divider period
  task automatic window();
    cnt = '{default: 0};
    repeat (1000) begin
      @(negedge sys_clk_i);
      cnt[0] += int'(!fb1_n);
      cnt[1] += int'(!fb2_n);
      cnt[2] += int'(!fb3_n);
      cnt[3] += int'(!sync_n);
      cnt[4] += int'(!fast_n);
      cnt[5] += int'(!slow_n);
      cnt[6] += int'(!psync_n);
    end
  endtask

  // Input pulses between two slow pulses; bounded so a dead output ends the run
  task automatic spacing(output int m);
    bit started;
    int k;
    m = 0;
    started = 0;
    for (k = 0; k < 8000; k++) begin
      @(negedge sys_clk_i);
      if (!slow_n) begin
        if (started) break;
        started = 1;
      end
      if (started) m += int'(in_en_i);
    end
    if (k == 8000) begin
      check(32'h1, 32'h0);
      end_sim();
    end
  endtask

  initial begin
    void'($urandom(32'h7b7ec64b));
    rst_b_i = 1'b0;
    en_mode = 2'h0;
    pclk = 1'b0;
    pen = 1'b1;
    a_n = 4'hf;
    b_n = 4'hf;
    present = 1'b1;
    inject = 1'b0;
    bor = 1'b0;
    fsync = 1'b1;
    repeat (12) @(posedge sys_clk_i);
    @(negedge sys_clk_i);
    check({addr_n, fb1_n, fb2_n, fb3_n, sync_n, slow_n, fast_n, slave}, 14'h3ffe);
    @(posedge sys_clk_i);
    rst_b_i <= 1'b1;
    // Abort: rise with enable low parks the counter, the fall enters period 6
    step(4'hf, 4'hf, 1'b1, 3'h0, 3'h0);
    step(4'hf, 4'hf, 1'b0, 3'h7, 3'h6);
    step(4'h5, 4'h0, 1'b1, 3'h7, 3'h7);
    for (int r = 0; r < 3; r++) begin
      bor <= 1'($urandom % 2);
      inject <= (r == 2);
      present <= (r != 1);
      for (int p = 0; p < 3; p++) begin
        av[p] = 4'($urandom % 10);
        bv[p] = 4'($urandom % 10);
      end
      // Hundreds never borrows, so the thousands digit stays zero
      av[3] = 4'h9;
      bv[3] = 4'($urandom % 9);
      av[4] = 4'h0;
      bv[4] = 4'h0;
      av[5] = 4'($urandom % 10);
      bv[5] = 4'($urandom % 10);
      prog();
      calc();
      en_mode = 2'h1;
      repeat (20) @(posedge sys_clk_i);
      window();
      check(cnt[0], 100 * d[0] + 10 * d[4] + 10 * inject);
      check(cnt[1], 100 * d[1]);
      check(cnt[2], 100 * d[2]);
      check(cnt[3], 100);
      check(cnt[4], 10);
      check(cnt[5], 1);
      check(cnt[6], 100);
      check(slave, 1'b0);
    end
    en_mode = 2'h2;
    spacing(n);
    check(n, 1000);
    // Slave pattern: tens-place fetch of eleven over ten, higher digits zero
    av = '{4'h3, 4'h2, 4'hb, 4'h0, 4'h0, 4'h0, 4'h0};
    bv = '{4'h1, 4'h4, 4'ha, 4'h0, 4'h0, 4'h0, 4'h0};
    prog();
    calc();
    en_mode = 2'h1;
    fsync <= 1'b0;
    repeat (20) @(posedge sys_clk_i);
    window();
    check(slave, 1'b1);
    check(cnt[2], bo ? 0 : 1000);
    check(cnt[6], 1000);
    // Half channel on with offset, modulus 16: ten by ten by sixteen by two pulses
    step(4'hf, 4'hf, 1'b0, 3'h7, 3'h6);
    step(4'hf, 4'h3, 1'b1, 3'h7, 3'h7);
    spacing(n);
    check(n, 3200);
    end_sim();
  end
endmodule

// File: rfd_divider.sv
`timescale 1ns/100ps
// Contract
// - A side-step pulse over a whole cycle adds one count to that cycle
// - Decade timing counter runs through ten states shared by four selectors
// - Selector with digit n is active in n of ten periods
// - In the always-free period the units selector passes the fractional one
// - Fractional selector timed by fractional counter, programmed by lowest digit
// - One fractional period passes the half selector output through
// - Half selector passes rate input in one state, or always when disabled
// - Units, tens, hundreds feedback drive three active-low outputs
// - Sync output low in last input period of each timing period
// - Tens digits eleven and ten, hundreds and thousands zero and period-five B zero select slave mode
// - A slave serves as two extra lower stages of the master
// - In slave mode third feedback carries subtractor borrow after period five
// - Borrow input sampled as subtractor borrow-in during fetch period zero
// - Slow output gives evenly spaced low pulses at the divided rate
// - Fast output rate is slow rate times modulus times half factor
// - Fast output may jitter one input period from side-stepping; here every decade repeats the same side-steps, so it stays evenly spaced
// - Half counter enabled by B bit zero high in fetch period six
// - Programme counter has eight states, seven fetch periods with own address
module rfd_divider (
  // Clock and reset
  input  wire logic                sys_clk_i,
  input  wire logic                rst_b_i,
  // Divider input, one pulse per input period
  input  wire logic                in_en_i,
  // Programme fetch pins
  input  wire rfd_pkg::rfd_fetch_t fetch_i,
  output logic [6:0]               data_addr_n_o,
  // Rate chain
  input  wire logic                rate_input_n_i,
  output logic                     feedback_out_first_n_o,
  output logic                     feedback_out_second_n_o,
  output logic                     feedback_out_third_n_o,
  output logic                     sync_n_o,
  // Divided outputs
  output logic                     slow_divided_out_n_o,
  output logic                     fast_out_n_o,
  output logic                     slave_mode_o
);
  import rfd_pkg::*;

  logic [2:0] pcnt;
  logic       pclk_q;
  logic       borrow_q;
  logic       slave_q;
  rfd_prog_t  prog;
  logic [3:0] pres_cnt;
  logic [3:0] pres_mod;
  logic [3:0] dec_cnt;
  logic [4:0] frac_cnt;
  logic       half_cnt;
  logic [3:0] sel_act;
  logic       half_act;
  logic       frac_act;
  logic       end_basic;
  logic       end_frac;
  logic       pc_rise;
  logic       pc_fall;
  logic [3:0] a_dig;
  logic [3:0] b_dig;
  logic [5:0] diff;
  logic [4:0] dig_mod;
  logic       next_borrow;
  logic [3:0] next_digit;

  assign pc_rise = fetch_i.programme_clock & ~pclk_q;
  assign pc_fall = ~fetch_i.programme_clock & pclk_q;
  assign a_dig   = ~fetch_i.data_a_n;
  assign b_dig   = ~fetch_i.data_b_n;

  // Edge detect on the slow programme clock
  always_ff @(posedge sys_clk_i) begin
    if (!rst_b_i) begin
      pclk_q <= 1'b0;
    end else begin
      pclk_q <= fetch_i.programme_clock;
    end
  end

  // Programme counter; enable low aborts to idle, then period 6 on the fall
  always_ff @(posedge sys_clk_i) begin
    if (!rst_b_i) begin
      pcnt <= RFD_PC_RESET;
    end else if (pc_rise) begin
      pcnt <= fetch_i.programme_enable ? pcnt + 3'h1 : RFD_PC_IDLE;
    end else if (pc_fall && !fetch_i.programme_enable && pcnt == RFD_PC_IDLE) begin
      pcnt <= RFD_FETCH_CONFIG;
    end
  end

  // One active-low address line per fetch period
  always_ff @(posedge sys_clk_i) begin
    if (!rst_b_i) begin
      data_addr_n_o <= 7'h7f;
    end else begin
      for (int i = 0; i < 7; i++) begin
        data_addr_n_o[i] <= !(pcnt == 3'(i));
      end
    end
  end

  // Digit subtractor; the lowest digit wraps at the fractional modulus
  always_comb begin
    dig_mod = (pcnt == RFD_FETCH_BORROW) ? prog.frac_mod : RFD_DEC_MOD;
    next_borrow = (pcnt == RFD_FETCH_BORROW) ? fetch_i.borrow_in : borrow_q;
    diff = {2'h0, a_dig} - {2'h0, b_dig} - {5'h00, next_borrow};
    next_digit = diff[3:0];
    if (diff[5]) begin
      next_digit = 4'(diff + {1'b0, dig_mod});
    end
  end

  // Programme word commits as the programme clock rises at the end of a fetch
  // period. One process owns the whole word so it keeps a single driver.
  // Period 6 is configuration (all-high A means a modulus of 16); period 5
  // moves only the borrow, since no digit register sits above thousands.
  always_ff @(posedge sys_clk_i) begin
    if (!rst_b_i) begin
      prog.digit      <= {4{RFD_DIGIT_RESET}};
      prog.frac_digit <= RFD_DIGIT_RESET;
      prog.frac_mod   <= RFD_FRAC_RESET;
      prog.half_en    <= 1'b0;
      prog.half_digit <= 1'b0;
      borrow_q        <= 1'b0;
    end else if (pc_rise && pcnt == RFD_FETCH_CONFIG) begin
      prog.frac_mod   <= (a_dig == 4'h0) ? RFD_FRAC_MAX : {1'b0, a_dig};
      prog.half_en    <= fetch_i.data_b_n[0];
      prog.half_digit <= fetch_i.data_b_n[1];
    end else if (pc_rise && pcnt <= RFD_FETCH_BOUT) begin
      borrow_q <= diff[5];
      if (pcnt == RFD_FETCH_BORROW) begin
        prog.frac_digit <= next_digit;
      end else if (pcnt != RFD_FETCH_BOUT) begin
        prog.digit[2'(pcnt - 3'h1)] <= next_digit;
      end
    end
  end

  // Slave pattern built up over periods 2 to 5
  always_ff @(posedge sys_clk_i) begin
    if (!rst_b_i) begin
      slave_q <= 1'b0;
    end else if (pc_rise) begin
      unique case (pcnt)
        RFD_FETCH_SLAVE:
          slave_q <= (a_dig == RFD_SLAVE_A) && (b_dig == RFD_SLAVE_B);
        RFD_FETCH_HIGH3, RFD_FETCH_HIGH4:
          slave_q <= slave_q && (a_dig == 4'h0) && (b_dig == 4'h0);
        RFD_FETCH_BOUT:
          slave_q <= slave_q && (b_dig == 4'h0);
        default: slave_q <= slave_q;
      endcase
    end
  end

  // Ten-eleven counter; modulus fixed at the start of each division cycle
  always_ff @(posedge sys_clk_i) begin
    if (!rst_b_i) begin
      pres_cnt <= 4'h0;
      pres_mod <= RFD_BASE_MOD;
    end else if (in_en_i) begin
      pres_cnt <= end_basic ? 4'h0 : pres_cnt + 4'h1;
      if (pres_cnt == 4'h0) begin
        pres_mod <= sel_act[3] ? RFD_STEP_MOD : RFD_BASE_MOD;
      end
    end
  end

  assign end_basic = in_en_i && pres_cnt != 4'h0 && pres_cnt == pres_mod - 4'h1;
  assign end_frac  = end_basic && dec_cnt == RFD_DEC_LAST
                   && frac_cnt == prog.frac_mod - 5'h01;

  // Decade, fractional and half counters step only at period boundaries
  always_ff @(posedge sys_clk_i) begin
    if (!rst_b_i) begin
      dec_cnt  <= 4'h0;
      frac_cnt <= 5'h00;
      half_cnt <= 1'b0;
    end else if (end_basic) begin
      dec_cnt <= (dec_cnt == RFD_DEC_LAST) ? 4'h0 : dec_cnt + 4'h1;
      if (dec_cnt == RFD_DEC_LAST) begin
        frac_cnt <= end_frac ? 5'h00 : frac_cnt + 5'h01;
      end
      if (end_frac) begin
        half_cnt <= prog.half_en & ~half_cnt;
      end
    end
  end

  // Half selector: rate input in state 0, offset digit in state 1
  always_comb begin
    if (!prog.half_en || !half_cnt) begin
      half_act = ~rate_input_n_i;
    end else begin
      half_act = prog.half_digit;
    end
  end

  // Fractional selector passes the half selector in its last period
  always_comb begin
    if (frac_cnt == prog.frac_mod - 5'h01) begin
      frac_act = half_act;
    end else begin
      frac_act = ({1'b0, frac_cnt} < {2'h0, prog.frac_digit});
    end
  end

  // Four decade selectors on the shared timing counter
  generate
    for (genvar k = 0; k < 4; k++) begin : g_sel
      rfd_rate_sel u_sel (
        .state_i  (dec_cnt),
        .digit_i  (prog.digit[k]),
        .pass_i   ((k == 0) ? frac_act : 1'b0),
        .active_o (sel_act[k])
      );
    end
  endgenerate

  // Feedback outputs; in slave mode the third carries the borrow out
  always_ff @(posedge sys_clk_i) begin
    if (!rst_b_i) begin
      feedback_out_first_n_o  <= 1'b1;
      feedback_out_second_n_o <= 1'b1;
      feedback_out_third_n_o  <= 1'b1;
      slave_mode_o            <= 1'b0;
    end else begin
      feedback_out_first_n_o  <= ~sel_act[0];
      feedback_out_second_n_o <= ~sel_act[1];
      feedback_out_third_n_o  <= slave_q ? borrow_q : ~sel_act[2];
      slave_mode_o            <= slave_q;
    end
  end

  // Sync low across the final input period of the timing period
  always_ff @(posedge sys_clk_i) begin
    if (!rst_b_i) begin
      sync_n_o <= 1'b1;
    end else begin
      sync_n_o <= !(pres_cnt != 4'h0 && pres_cnt == pres_mod - 4'h1);
    end
  end

  // Fast pulse per fractional step; slow pulse once per full programme
  // cycle. Fast pulses stay evenly spaced since every decade repeats the same side-steps.
  always_ff @(posedge sys_clk_i) begin
    if (!rst_b_i) begin
      fast_out_n_o         <= 1'b1;
      slow_divided_out_n_o <= 1'b1;
    end else begin
      fast_out_n_o <= !(end_basic && dec_cnt == RFD_DEC_LAST);
      slow_divided_out_n_o <= !(end_frac && (!prog.half_en || half_cnt));
    end
  end

  // Checks on the counter chain and fetch sequencing
  sequence s_cycle_start;
    in_en_i && pres_cnt == 4'h0;
  endsequence

  sequence s_fetch_step;
    pc_rise && fetch_i.programme_enable && pcnt == 3'h2;
  endsequence

  property p_dec_range;
    @(posedge sys_clk_i) disable iff (!rst_b_i) dec_cnt <= 4'h9;
  endproperty
  a_dec_range: assert property (p_dec_range) else $error("decade out of range");

  property p_sidestep;
    @(posedge sys_clk_i) disable iff (!rst_b_i)
      s_cycle_start |=> pres_mod == ($past(sel_act[3]) ? 4'hb : 4'ha);
  endproperty
  a_sidestep: assert property (p_sidestep) else $error("side-step modulus wrong");

  property p_units_pass;
    @(posedge sys_clk_i) disable iff (!rst_b_i)
      dec_cnt == 4'h9 |=> feedback_out_first_n_o == !$past(frac_act);
  endproperty
  a_units_pass: assert property (p_units_pass) else $error("units pass wrong");

  property p_sync;
    @(posedge sys_clk_i) disable iff (!rst_b_i)
      end_basic |-> ##1 !sync_n_o ##1 sync_n_o;
  endproperty
  a_sync: assert property (p_sync) else $error("sync not in last period");

  property p_slow_on_fast;
    @(posedge sys_clk_i) disable iff (!rst_b_i) !slow_divided_out_n_o |-> !fast_out_n_o;
  endproperty
  a_slow_on_fast: assert property (p_slow_on_fast) else $error("slow without fast");

  property p_addr;
    @(posedge sys_clk_i) disable iff (!rst_b_i)
      $countones(~data_addr_n_o) <= 1;
  endproperty
  a_addr: assert property (p_addr) else $error("two address lines low");

  property p_fetch_step;
    @(posedge sys_clk_i) disable iff (!rst_b_i)
      s_fetch_step |=> pcnt == 3'h3 ##1 !data_addr_n_o[3];
  endproperty
  a_fetch_step: assert property (p_fetch_step) else $error("fetch did not step");

  property p_borrow_out;
    @(posedge sys_clk_i) disable iff (!rst_b_i)
      slave_q |=> feedback_out_third_n_o == $past(borrow_q);
  endproperty
  a_borrow_out: assert property (p_borrow_out) else $error("borrow not on third");

  property p_half_off;
    @(posedge sys_clk_i) disable iff (!rst_b_i)
      !prog.half_en && end_frac |=> !half_cnt;
  endproperty
  a_half_off: assert property (p_half_off) else $error("half counter ran");

endmodule

// File: rfd_next_stage.sv
`timescale 1ns/100ps
// Following divider or prescaler as seen from the divider's cascade pins
module rfd_next_stage (
  // Cascade options
  input  wire logic present_i,
  input  wire logic inject_i,
  input  wire logic borrow_i,
  // Sync lines of the prescaler chain
  input  wire logic sync_n_i,
  input  wire logic follow_sync_n_i,
  // Lines into the divider
  output logic      rate_n_o,
  output logic      borrow_o,
  // Timing for the earlier prescaler
  output logic      prev_sync_n_o
);
  // Earlier prescaler is timed while either sync line is low
  assign prev_sync_n_o = sync_n_i & follow_sync_n_i;
  // An absent follower leaves the rate line high so no false feedback enters
  assign rate_n_o = ~(present_i & inject_i);
  // Borrow chain is grounded when no follower exists
  assign borrow_o = present_i & borrow_i;
endmodule

// File: rfd_pkg.sv
package rfd_pkg;

  // Programme counter: eight states, fetch periods 0 to 6, state 7 idle
  localparam logic [2:0] RFD_PC_IDLE      = 3'h7;
  localparam logic [2:0] RFD_PC_RESET     = 3'h7;
  localparam logic [2:0] RFD_FETCH_BORROW = 3'h0;
  localparam logic [2:0] RFD_FETCH_SLAVE  = 3'h2;
  localparam logic [2:0] RFD_FETCH_HIGH3  = 3'h3;
  localparam logic [2:0] RFD_FETCH_HIGH4  = 3'h4;
  localparam logic [2:0] RFD_FETCH_BOUT   = 3'h5;
  localparam logic [2:0] RFD_FETCH_CONFIG = 3'h6;

  // Slave mode pattern for the tens digits
  localparam logic [3:0] RFD_SLAVE_A = 4'hb;
  localparam logic [3:0] RFD_SLAVE_B = 4'ha;

  // Decade timing and prescaler moduli
  localparam logic [3:0] RFD_DEC_LAST   = 4'h9;
  localparam logic [3:0] RFD_BASE_MOD   = 4'ha;
  localparam logic [3:0] RFD_STEP_MOD   = 4'hb;
  localparam logic [4:0] RFD_DEC_MOD    = 5'h0a;
  localparam logic [4:0] RFD_FRAC_MAX   = 5'h10;

  // Values after reset
  localparam logic [4:0] RFD_FRAC_RESET = 5'h0a;
  localparam logic [3:0] RFD_DIGIT_RESET = 4'h0;

  // Programme held by the divider
  typedef struct packed {
    logic [3:0][3:0] digit;      // Decade digits units..thousands
    logic [3:0]      frac_digit; // Lowest programme digit
    logic [4:0]      frac_mod;   // Fractional modulus 1..16
    logic            half_en;    // Half channel counter enabled
    logic            half_digit; // Half channel offset
  } rfd_prog_t;

  // Fetch handshake pins
  typedef struct packed {
    logic       programme_clock;
    logic       programme_enable;
    logic [3:0] data_a_n;
    logic [3:0] data_b_n;
    logic       borrow_in;
  } rfd_fetch_t;

endpackage

// File: rfd_rate_sel.sv
`timescale 1ns/100ps
// One decade rate selector: active in n of ten timing periods, and in the
// last period, which a digit never reaches, it passes the lower selector on.
module rfd_rate_sel (
  // Timing and programme
  input  wire logic [3:0] state_i,
  input  wire logic [3:0] digit_i,
  // Chain
  input  wire logic       pass_i,
  output logic            active_o
);
  import rfd_pkg::*;

  // A digit never exceeds nine, so state nine is always free for the pass
  always_comb begin
    if (state_i == RFD_DEC_LAST) begin
      active_o = pass_i;
    end else begin
      active_o = (state_i < digit_i);
    end
  end

endmodule
